/* File: src/bcd_out_params.svh */
// Purpose: Offsets, field positions, reset values and timing for the BCD output port
// Assumes: 32-bit APB, 125 MHz pclk
// Notes:   Definitions only
`ifndef BCD_OUT_PARAMS_SVH
`define BCD_OUT_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BCD_OFS_CTRL        12'h000
`define BCD_OFS_WEIGHT      12'h004
`define BCD_OFS_PRINT       12'h008
`define BCD_OFS_STATUS      12'h00C

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define BCD_CTRL_TIMING_LSB 0
`define BCD_CTRL_TIMING_MSB 1
`define BCD_CTRL_DPOL_BIT   2
`define BCD_CTRL_SPOL_BIT   3
`define BCD_CTRL_RATE_LSB   4
`define BCD_CTRL_RATE_MSB   5
`define BCD_CTRL_RESET      32'h0000_000D

// ----------------------------------------------------------------
// Weight fields
// ----------------------------------------------------------------
`define BCD_W_DIGITS_MSB    23
`define BCD_W_OVER_BIT      24
`define BCD_W_NEG_BIT       25
`define BCD_W_STABLE_BIT    26
`define BCD_W_NET_BIT       27
`define BCD_W_DP_LSB        28
`define BCD_W_DP_MSB        29
`define BCD_W_UNIT_LSB      30
`define BCD_W_UNIT_MSB      31
`define BCD_WEIGHT_RESET    32'h0000_0000

// ----------------------------------------------------------------
// Print trigger and status fields
// ----------------------------------------------------------------
`define BCD_PRINT_AUTO_BIT  0
`define BCD_PRINT_MAN_BIT   1
`define BCD_ST_HOLD_BIT     0
`define BCD_ST_FROZEN_BIT   1
`define BCD_ST_STROBE_BIT   2
`define BCD_ST_VALID_BIT    3
`define BCD_ST_PEND_BIT     4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BCD_CLK_MHZ         125
`define BCD_STROBE_20_MS    20
`define BCD_STROBE_10_MS    45
`define BCD_STROBE_5_MS     95
`define BCD_PERIOD_20_MS    50
`define BCD_PERIOD_10_MS    100
`define BCD_PERIOD_5_MS     200
`define BCD_MS_TO_CYC(ms)   ((ms) * `BCD_CLK_MHZ * 1000)

`endif

/* File: src/bcd_out_pkg.sv */
// Purpose: Types for the BCD output port
// Assumes: Used by bcd_parallel_weight_output
// Notes:   Codes of the two-bit mode fields
package bcd_out_pkg;

    typedef enum logic [1:0] {
        TM_RESERVED     = 2'h0,
        TM_INTERVAL     = 2'h1,
        TM_AUTO_PRINT   = 2'h2,
        TM_MANUAL_PRINT = 2'h3
    } timing_mode_t;

    typedef enum logic [1:0] {
        RATE_20 = 2'h0,
        RATE_10 = 2'h1,
        RATE_5  = 2'h2,
        RATE_X  = 2'h3
    } refresh_rate_t;

    typedef enum {
        PH_IDLE,
        PH_STROBE,
        PH_TAIL
    } phase_t;

endpackage : bcd_out_pkg

/* File: src/bcd_parallel_weight_output.sv */
// Purpose: Parallel BCD weight output with strobe, hold and APB control
// Assumes: 125 MHz pclk; hold_in high means hold ON
// Notes:   Pin levels carry polarity; ON is the logical active state
//
// Behaviour
// RQ1: Output timing is periodic at the refresh rate, or follows auto print, or manual print.
// RQ2: Each new word stays on the data lines for twice the strobe width.
// RQ3: The reader samples data only within the twice-strobe valid window.
// RQ4: Strobe is 20, 45 or 95 ms at 20, 10 or 5 updates per second.
// RQ5: Within 50 ms of hold ON, data and strobe stop updating and keep the last value.
// RQ6: Within 50 ms of hold OFF, normal updates resume.
// RQ7: Data and strobe polarity are set independently, negative logic by default.
// RQ8: On overload with negative data logic every data line is driven ON.
// RQ9: The net line is ON for net weight and OFF for gross or tare.
// RQ10: Magnitude appears as six BCD digits, lines weighted 1, 2, 4, 8, units first.
// RQ11: Sign ON when positive, overload OFF on overload, stable ON, two-bit point and unit codes.
`timescale 1ns/1ns
`include "bcd_out_params.svh"
module bcd_parallel_weight_output #(
    parameter int unsigned STROBE_20_CYC = `BCD_MS_TO_CYC(`BCD_STROBE_20_MS),
    parameter int unsigned STROBE_10_CYC = `BCD_MS_TO_CYC(`BCD_STROBE_10_MS),
    parameter int unsigned STROBE_5_CYC  = `BCD_MS_TO_CYC(`BCD_STROBE_5_MS),
    parameter int unsigned PERIOD_20_CYC = `BCD_MS_TO_CYC(`BCD_PERIOD_20_MS),
    parameter int unsigned PERIOD_10_CYC = `BCD_MS_TO_CYC(`BCD_PERIOD_10_MS),
    parameter int unsigned PERIOD_5_CYC  = `BCD_MS_TO_CYC(`BCD_PERIOD_5_MS)
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Hold input pin
    input  wire logic        hold_in,
    // BCD output pins
    output logic      [23:0] data_lines,
    output logic             overload_line,
    output logic             sign_line,
    output logic             stable_line,
    output logic             net_line,
    output logic      [1:0]  dp_line,
    output logic      [1:0]  unit_line,
    output logic             strobe_line
);

    // ----------------------------------------------------------------
    // Hold synchroniser
    // ----------------------------------------------------------------
    logic hold_s;

    hold_sync u_hold_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (hold_in),
        .sync_out (hold_s)
    );

    // ----------------------------------------------------------------
    // APB registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q,   ctrl_d;
    logic [31:0] weight_q, weight_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic        auto_req, man_req;
    logic        apb_do;
    logic [31:0] status;
    logic        pend_q, pend_d;

    bcd_out_pkg::phase_t        ph_q, ph_d;
    bcd_out_pkg::timing_mode_t  mode;
    bcd_out_pkg::refresh_rate_t rate;

    assign apb_do = psel && penable && pready;
    assign mode   = bcd_out_pkg::timing_mode_t'(ctrl_q[`BCD_CTRL_TIMING_MSB:`BCD_CTRL_TIMING_LSB]);
    assign rate   = bcd_out_pkg::refresh_rate_t'(ctrl_q[`BCD_CTRL_RATE_MSB:`BCD_CTRL_RATE_LSB]);

    always_comb begin
        status                     = 32'h0000_0000;
        status[`BCD_ST_HOLD_BIT]   = hold_s;
        status[`BCD_ST_FROZEN_BIT] = hold_s;
        status[`BCD_ST_STROBE_BIT] = (ph_q == bcd_out_pkg::PH_STROBE);
        status[`BCD_ST_VALID_BIT]  = (ph_q != bcd_out_pkg::PH_IDLE);
        status[`BCD_ST_PEND_BIT]   = pend_q;
    end

    always_comb begin
        ctrl_d    = ctrl_q;
        weight_d  = weight_q;
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        pready_d  = psel && !penable;
        auto_req  = 1'b0;
        man_req   = 1'b0;
        if (psel && !penable) begin
            if (paddr == `BCD_OFS_CTRL) begin
                prdata_d = ctrl_q;
            end else if (paddr == `BCD_OFS_WEIGHT) begin
                prdata_d = weight_q;
            end else if (paddr == `BCD_OFS_PRINT) begin
                prdata_d = 32'h0000_0000;
            end else if (paddr == `BCD_OFS_STATUS) begin
                prdata_d = status;
            end else begin
                pslverr_d = 1'b1;
            end
        end else if (apb_do) begin
            prdata_d  = prdata;
            pslverr_d = pslverr;
        end
        if (apb_do && pwrite) begin
            if (paddr == `BCD_OFS_CTRL) begin
                ctrl_d = {26'h000_0000, pwdata[5:0]};
            end else if (paddr == `BCD_OFS_WEIGHT) begin
                weight_d = pwdata;
            end else if (paddr == `BCD_OFS_PRINT) begin
                auto_req = pwdata[`BCD_PRINT_AUTO_BIT];
                man_req  = pwdata[`BCD_PRINT_MAN_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= `BCD_CTRL_RESET;
            weight_q <= `BCD_WEIGHT_RESET;
            prdata   <= 32'h0000_0000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            weight_q <= weight_d;
            prdata   <= prdata_d;
            pready   <= pready_d;
            pslverr  <= pslverr_d;
        end
    end

    // ----------------------------------------------------------------
    // Update scheduling and strobe sequence
    // ----------------------------------------------------------------
    logic [31:0] strobe_cyc, period_cyc;
    logic [31:0] per_cnt_q, per_cnt_d;
    logic [31:0] ph_cnt_q,  ph_cnt_d;
    logic        trigger, fire;
    logic [31:0] snap_q, snap_d;

    always_comb begin
        strobe_cyc = STROBE_20_CYC; // RQ4
        period_cyc = PERIOD_20_CYC;
        if (rate == bcd_out_pkg::RATE_10) begin
            strobe_cyc = STROBE_10_CYC; // RQ4
            period_cyc = PERIOD_10_CYC;
        end else if (rate == bcd_out_pkg::RATE_5) begin
            strobe_cyc = STROBE_5_CYC; // RQ4
            period_cyc = PERIOD_5_CYC;
        end
    end

    always_comb begin
        per_cnt_d = per_cnt_q + 32'h0000_0001;
        trigger   = 1'b0;
        if (per_cnt_q >= period_cyc - 32'h0000_0001) begin
            per_cnt_d = 32'h0000_0000;
        end
        case (mode)
            bcd_out_pkg::TM_AUTO_PRINT:   trigger = auto_req; // RQ1
            bcd_out_pkg::TM_MANUAL_PRINT: trigger = man_req; // RQ1
            default:                      trigger = (per_cnt_q == 32'h0000_0000); // RQ1
        endcase
        // A request that fires at once is consumed; one arriving while an older pending one fires stays pending
        fire   = (pend_q || trigger) && !hold_s && (ph_q == bcd_out_pkg::PH_IDLE); // RQ5 RQ6
        pend_d = pend_q;
        if (fire) begin
            pend_d = 1'b0;
        end
        if (trigger && mode != bcd_out_pkg::TM_INTERVAL && mode != bcd_out_pkg::TM_RESERVED) begin
            pend_d = 1'b1;
        end
        if (fire && !trigger) begin
            pend_d = 1'b0;
        end
        snap_d   = snap_q;
        ph_d     = ph_q;
        ph_cnt_d = ph_cnt_q + 32'h0000_0001;
        case (ph_q)
            bcd_out_pkg::PH_IDLE: begin
                ph_cnt_d = 32'h0000_0000;
                if (fire) begin
                    snap_d = weight_q;
                    ph_d   = bcd_out_pkg::PH_STROBE;
                end
            end
            bcd_out_pkg::PH_STROBE: begin
                if (ph_cnt_q >= strobe_cyc - 32'h0000_0001) begin
                    ph_d = bcd_out_pkg::PH_TAIL;
                end
            end
            default: begin
                // Data held for a second strobe width
                if (ph_cnt_q >= (strobe_cyc << 1) - 32'h0000_0001) begin // RQ2
                    ph_d = bcd_out_pkg::PH_IDLE;
                end
            end
        endcase
        if (fire && ph_q == bcd_out_pkg::PH_IDLE && mode != bcd_out_pkg::TM_INTERVAL
                && mode != bcd_out_pkg::TM_RESERVED) begin
            pend_d = trigger && !pend_q ? 1'b0 : pend_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_q <= 32'h0000_0000;
            ph_cnt_q  <= 32'h0000_0000;
            ph_q      <= bcd_out_pkg::PH_IDLE;
            pend_q    <= 1'b0;
            snap_q    <= `BCD_WEIGHT_RESET;
        end else begin
            per_cnt_q <= per_cnt_d;
            ph_cnt_q  <= ph_cnt_d;
            ph_q      <= ph_d;
            pend_q    <= pend_d;
            snap_q    <= snap_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers with polarity
    // ----------------------------------------------------------------
    logic        dneg, sneg;
    logic [23:0] data_on;
    logic [23:0] data_d;
    logic        over_d, sign_d, stab_d, net_d, strobe_d;
    logic [1:0]  dp_d, unit_d;

    assign dneg = ctrl_q[`BCD_CTRL_DPOL_BIT];
    assign sneg = ctrl_q[`BCD_CTRL_SPOL_BIT];

    always_comb begin
        data_on = snap_q[`BCD_W_DIGITS_MSB:0]; // RQ10
        if (snap_q[`BCD_W_OVER_BIT] && dneg) begin
            data_on = 24'hFF_FFFF; // RQ8
        end
        // ON maps to low level under negative logic
        data_d   = data_on ^ {24{dneg}}; // RQ7
        over_d   = !snap_q[`BCD_W_OVER_BIT] ^ dneg; // RQ11
        sign_d   = !snap_q[`BCD_W_NEG_BIT] ^ dneg; // RQ11
        stab_d   = snap_q[`BCD_W_STABLE_BIT] ^ dneg; // RQ11
        net_d    = snap_q[`BCD_W_NET_BIT] ^ dneg; // RQ9
        dp_d     = snap_q[`BCD_W_DP_MSB:`BCD_W_DP_LSB] ^ {2{dneg}}; // RQ11
        unit_d   = snap_q[`BCD_W_UNIT_MSB:`BCD_W_UNIT_LSB] ^ {2{dneg}}; // RQ11
        strobe_d = (ph_q == bcd_out_pkg::PH_STROBE) ^ sneg; // RQ7
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_lines    <= 24'hFF_FFFF;
            overload_line <= 1'b0;
            sign_line     <= 1'b0;
            stable_line   <= 1'b1;
            net_line      <= 1'b1;
            dp_line       <= 2'h3;
            unit_line     <= 2'h3;
            strobe_line   <= 1'b1;
        end else begin
            data_lines    <= data_d;
            overload_line <= over_d;
            sign_line     <= sign_d;
            stable_line   <= stab_d;
            net_line      <= net_d;
            dp_line       <= dp_d;
            unit_line     <= unit_d;
            strobe_line   <= strobe_d;
        end
    end

endmodule : bcd_parallel_weight_output

/* File: src/hold_sync.sv */
// Purpose: Two-stage synchroniser for the hold input pin
// Assumes: Asynchronous pin, pclk domain
// Notes:   First stage read only by second stage
`timescale 1ns/1ns
module hold_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and result
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : hold_sync

/* File: verification/bcd_out_checker_properties.sv */
// Purpose: Port-level checks of the BCD weight output
// Assumes: Small strobe counts, shortest strobe 4 cycles
// Notes:   Bound to the top module
`timescale 1ns/1ns
module bcd_out_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        hold_in,
    input wire logic [23:0] data_lines,
    input wire logic        overload_line,
    input wire logic        sign_line,
    input wire logic        stable_line,
    input wire logic        net_line,
    input wire logic [1:0]  dp_line,
    input wire logic [1:0]  unit_line,
    input wire logic        strobe_line
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("No answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready longer than one cycle");
    a_unmapped_err: assert property (psel && !penable && paddr > 12'h00C
        |=> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("Unmapped access not refused");
    a_mapped_ok: assert property (psel && !penable && paddr <= 12'h00C |=> !pslverr)
        else $error("Mapped access refused");
    a_print_zero: assert property (psel && !penable && !pwrite && paddr == 12'h008
        |=> prdata == 32'h0000_0000)
        else $error("Print register read not zero");
    a_reset_pins: assert property ($rose(presetn) |-> data_lines == 24'hFF_FFFF
        && strobe_line && stable_line && net_line && !overload_line && !sign_line
        && dp_line == 2'h3 && unit_line == 2'h3)
        else $error("Pins wrong after reset");
    a_hold_freeze: assert property (hold_in [*6] |-> $stable(data_lines))
        else $error("Data changed while held");
    // Level flips caused by a control write are polarity changes, not pulses
    a_strobe_min: assert property ($changed(strobe_line)
        && !$past(psel && penable && pready && pwrite && paddr == 12'h000, 2)
        |=> $stable(strobe_line) [*3])
        else $error("Strobe shorter than four cycles");
endmodule : bcd_out_checker

bind bcd_parallel_weight_output bcd_out_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hold_in(hold_in),
    .data_lines(data_lines), .overload_line(overload_line), .sign_line(sign_line),
    .stable_line(stable_line), .net_line(net_line), .dp_line(dp_line),
    .unit_line(unit_line), .strobe_line(strobe_line)
);

/* File: verification/bcd_reader_model.sv */
// Purpose: External reader of the parallel BCD pins
// Assumes: Strobe polarity told by the bench
// Notes:   Samples one cycle into the strobe, measures its width
`timescale 1ns/1ns
module bcd_reader_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Observed pins
    input  wire logic [31:0] pins,
    input  wire logic        strobe_line,
    input  wire logic        strobe_neg,
    // Results
    output logic      [31:0] cap_q,
    output logic      [7:0]  width_q,
    output int               n_cap
);
    logic       on;
    logic       on_q;
    logic [7:0] cnt;
    assign on = strobe_line ^ strobe_neg;
    // ------------------------------------------------
    // Sampling
    // ------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q    <= 1'b0;
            cnt     <= 8'h00;
            cap_q   <= 32'h0000_0000;
            width_q <= 8'h00;
            n_cap   <= 0;
        end else begin
            on_q <= on;
            if (on)
                cnt <= cnt + 8'h01;
            if (on && cnt == 8'h01)
                cap_q <= pins;
            if (on_q && !on) begin
                width_q <= cnt;
                n_cap   <= n_cap + 1;
                cnt     <= 8'h00;
            end
        end
    end
endmodule : bcd_reader_model

/* File: verification/tb_bcd_parallel_weight_output.sv */
// Purpose: Self-checking bench of the BCD weight output
// Assumes: Strobe 4/6/8 and period 12/16/20 cycles
// Notes:   Reader model captures each strobed word
`timescale 1ns/1ns
module tb_bcd_parallel_weight_output;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        hold_in = 1'b0;
    logic        strobe_neg = 1'b1;
    logic [31:0] prdata, cap_q, rd;
    logic [23:0] data_lines;
    logic [1:0]  dp_line, unit_line;
    logic        pready, pslverr, overload_line, sign_line, stable_line, net_line;
    logic        strobe_line, er;
    logic [7:0]  width_q;
    int          n_cap, t, mismatches = 0, n_tests = 0, cyc = 0;
    wire  [31:0] pins = {unit_line, dp_line, net_line, stable_line, sign_line, overload_line,
                         data_lines};

    // Scaled strobe widths and periods, each period above twice its strobe
    localparam int S20 = 4;
    localparam int S10 = 6;
    localparam int S5  = 8;
    localparam int P20 = 12;
    localparam int P10 = 16;
    localparam int P5  = 20;

    bcd_parallel_weight_output #(.STROBE_20_CYC(S20), .STROBE_10_CYC(S10), .STROBE_5_CYC(S5),
        .PERIOD_20_CYC(P20), .PERIOD_10_CYC(P10), .PERIOD_5_CYC(P5)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hold_in(hold_in), .data_lines(data_lines), .overload_line(overload_line),
        .sign_line(sign_line), .stable_line(stable_line), .net_line(net_line),
        .dp_line(dp_line), .unit_line(unit_line), .strobe_line(strobe_line));
    bcd_reader_model u_reader (.pclk(pclk), .presetn(presetn), .pins(pins),
        .strobe_line(strobe_line), .strobe_neg(strobe_neg), .cap_q(cap_q),
        .width_q(width_q), .n_cap(n_cap));

    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    function automatic logic [31:0] exp_pins(input logic [31:0] w, input logic dneg);
        logic [31:0] on;
        on = {w[31:26], ~w[25:24], w[23:0]};
        if (w[24] && dneg)
            on[23:0] = 24'hFF_FFFF;
        return on ^ {32{dneg}};
    endfunction : exp_pins
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_cap(input int target, output int n);
        for (n = 0; n < 400 && n_cap < target; n++)
            @(posedge pclk);
        check({31'h0, n_cap >= target}, 32'h0000_0001);
    endtask : wait_cap
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs();
        check({pins[31:1], strobe_line}, exp_pins(32'h0000_0000, 1'b1) | 32'h1);
        apb(1'b0, 12'h000, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_000D);
        apb(1'b1, 12'h010, 32'h0000_0002, rd, er);
        apb(1'b0, 12'h010, 32'h0000_0000, rd, er);
        check({rd[30:0], er}, 32'h0000_0001);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_rates();
        int wid [3] = '{S20, S10, S5};
        int per [3] = '{P20, P10, P5};
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, 12'h004, 32'h4698_7601 + 32'(r), rd, er);
            apb(1'b1, 12'h000, 32'h0000_000D | (32'(r) << 4), rd, er);
            wait_cap(n_cap + 2, t);
            check({24'h0, width_q}, 32'(wid[r]));
            check(cap_q, exp_pins(32'h4698_7601 + 32'(r), 1'b1));
            wait_cap(n_cap + 1, t);
            check(32'(t), 32'(per[r]));
        end
        $display("t_rates done");
    endtask : t_rates
    task automatic t_print();
        int base;
        apb(1'b1, 12'h000, 32'h0000_0002, rd, er);
        // Strobe pin takes the new polarity one edge after the write
        @(posedge pclk);
        strobe_neg <= 1'b0;
        repeat (20) @(posedge pclk);
        base = n_cap;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h004, 32'hB981_2345 - 32'(k), rd, er);
            if (k == 1)
                apb(1'b1, 12'h000, 32'h0000_0003, rd, er);
            repeat (40) @(posedge pclk);
            check(32'(n_cap), 32'(base + k));
            apb(1'b1, 12'h008, 32'(k + 1), rd, er);
            wait_cap(base + k + 1, t);
            check(cap_q, exp_pins(32'hB981_2345 - 32'(k), 1'b0));
        end
        $display("t_print done");
    endtask : t_print
    task automatic t_hold();
        int          base;
        logic [31:0] held;
        apb(1'b1, 12'h000, 32'h0000_000D, rd, er);
        @(posedge pclk);
        strobe_neg <= 1'b1;
        apb(1'b1, 12'h004, 32'h0599_9999, rd, er);
        repeat (20) @(posedge pclk);
        wait_cap(n_cap + 1, t);
        check(cap_q, exp_pins(32'h0599_9999, 1'b1));
        hold_in <= 1'b1;
        repeat (30) @(posedge pclk);
        apb(1'b0, 12'h00C, 32'h0000_0000, rd, er);
        check({31'h0, rd[0]}, 32'h0000_0001);
        base = n_cap;
        held = pins;
        apb(1'b1, 12'h004, 32'h0012_3456, rd, er);
        repeat (60) @(posedge pclk);
        check(32'(n_cap), 32'(base));
        check(pins, held);
        hold_in <= 1'b0;
        wait_cap(base + 1, t);
        check(cap_q, exp_pins(32'h0012_3456, 1'b1));
        $display("t_hold done");
    endtask : t_hold

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_rates();
        t_print();
        t_hold();
        wrap_up();
    end
endmodule : tb_bcd_parallel_weight_output
